//--- core/hbm_pkg.sv
// Constants shared by the hardware byte multiplier files
package hbm_pkg;

   // ***************************************************
   // Register byte addresses
   // ***************************************************
   localparam int HBM_ADDR_W = 12;
   localparam logic [11:0] HBM_OFS_PROD_LOW = 12'h000;
   localparam logic [11:0] HBM_OFS_PROD_HIGH = 12'h004;
   localparam logic [11:0] HBM_OFS_ACCUM = 12'h008;
   localparam logic [11:0] HBM_OFS_FILE_OP = 12'h00C;
   localparam logic [11:0] HBM_OFS_COMMAND = 12'h010;
   localparam logic [11:0] HBM_OFS_FLAGS = 12'hFD8;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int HBM_FLAG_CARRY = 0;
   localparam int HBM_FLAG_DIGIT = 1;
   localparam int HBM_FLAG_ZERO = 2;
   localparam int HBM_FLAG_OVER = 3;
   localparam int HBM_FLAG_NEG = 4;
   localparam int HBM_FLAG_W = 5;
   localparam int HBM_CMD_MUL = 0;
   localparam int HBM_CMD_SUB = 1;

   // ***************************************************
   // Values after reset
   // ***************************************************
   localparam logic [7:0] HBM_RST_BYTE = 8'h00;
   localparam logic [4:0] HBM_RST_FLAGS = 5'h00;

   // ***************************************************
   // Bus response codes
   // ***************************************************
   localparam logic [1:0] HBM_RESP_OKAY = 2'h0;
   localparam logic [1:0] HBM_RESP_SLVERR = 2'h2;

endpackage

//--- core/hbm_mult_core.sv
// Combinational unsigned byte by byte multiplier array
`timescale 1ns/1ps
`default_nettype none

module hbm_mult_core #(
   parameter int OPER_W = 8
) (
   input wire logic [OPER_W-1:0] operandA,
   input wire logic [OPER_W-1:0] operandB,
   output logic [2*OPER_W-1:0] product
);

   // ***************************************************
   // Full width unsigned product
   // ***************************************************
   always_comb begin
      // Both operands widened, no sign extension
      product = {{OPER_W{1'b0}}, operandA} * {{OPER_W{1'b0}}, operandB};
   end

endmodule

`default_nettype wire

//--- core/hbm_top.sv
// Hardware byte multiplier with its AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module hbm_top
   import hbm_pkg::*;
#(
   parameter int ADDR_W = HBM_ADDR_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   // ***************************************************
   // Datapath state
   // ***************************************************
   logic [7:0] prodLow_q, prodLow_d; // Product low byte
   logic [7:0] prodHigh_q, prodHigh_d; // Product high byte
   logic [7:0] accum_q, accum_d; // Working accumulator
   logic [7:0] fileOp_q, fileOp_d; // Memory operand
   logic [4:0] flags_q, flags_d; // Condition flags
   logic [15:0] mulProduct; // Array output

   // ***************************************************
   // Write channel state
   // ***************************************************
   logic awHeld_q, awHeld_d; // Address waiting
   logic [ADDR_W-1:0] awAddr_q, awAddr_d;
   logic wHeld_q, wHeld_d; // Data waiting
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic awReady_q, awReady_d;
   logic wReady_q, wReady_d;
   logic bValid_q, bValid_d;
   logic [1:0] bResp_q, bResp_d;

   // ***************************************************
   // Read channel state
   // ***************************************************
   logic arReady_q, arReady_d;
   logic rValid_q, rValid_d;
   logic [31:0] rData_q, rData_d;
   logic [1:0] rResp_q, rResp_d;

   // Commit a write once address and data are both in
   logic doWrite;
   logic [8:0] subSum; // Subtract by adding inverse
   logic [4:0] subNib; // Low nibble for digit carry
   logic [7:0] subRes;

   // ***************************************************
   // Multiplier array
   // ***************************************************
   hbm_mult_core #(
      .OPER_W(8)
   ) u_mult (
      .operandA(accum_q),
      .operandB(fileOp_q),
      .product(mulProduct)
   );

   // ***************************************************
   // Write channel and register updates
   // ***************************************************
   always_comb begin
      awHeld_d = awHeld_q;
      awAddr_d = awAddr_q;
      wHeld_d = wHeld_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      prodLow_d = prodLow_q;
      prodHigh_d = prodHigh_q;
      accum_d = accum_q;
      fileOp_d = fileOp_q;
      flags_d = flags_q;
      subSum = {1'b0, prodHigh_q} + {1'b0, ~accum_q} + 9'h001;
      subNib = {1'b0, prodHigh_q[3:0]} + {1'b0, ~accum_q[3:0]} + 5'h01;
      subRes = subSum[7:0];
      doWrite = awHeld_q && wHeld_q && !bValid_q;
      // Capture address
      if (awvalid && awReady_q) begin
         awHeld_d = 1'b1;
         awAddr_d = awaddr;
      end
      // Capture data
      if (wvalid && wReady_q) begin
         wHeld_d = 1'b1;
         wData_d = wdata;
         wStrb_d = wstrb;
      end
      // Response handshake
      if (bValid_q && bready) begin
         bValid_d = 1'b0;
      end
      if (doWrite) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
         bResp_d = HBM_RESP_OKAY;
         if (awAddr_q == HBM_OFS_PROD_LOW) begin
            if (wStrb_q[0]) begin
               prodLow_d = wData_q[7:0];
            end
         end else if (awAddr_q == HBM_OFS_PROD_HIGH) begin
            // Sign correction path for software
            if (wStrb_q[0]) begin
               prodHigh_d = wData_q[7:0];
            end
         end else if (awAddr_q == HBM_OFS_ACCUM) begin
            if (wStrb_q[0]) begin
               accum_d = wData_q[7:0];
            end
         end else if (awAddr_q == HBM_OFS_FILE_OP) begin
            if (wStrb_q[0]) begin
               fileOp_d = wData_q[7:0];
            end
         end else if (awAddr_q == HBM_OFS_FLAGS) begin
            if (wStrb_q[0]) begin
               flags_d = wData_q[HBM_FLAG_W-1:0];
            end
         end else if (awAddr_q == HBM_OFS_COMMAND) begin
            if (wStrb_q[0] && wData_q[HBM_CMD_MUL]) begin
               // Both bytes in one edge; flags and operands kept
               prodHigh_d = mulProduct[15:8];
               prodLow_d = mulProduct[7:0];
               flags_d = flags_q;
            end else if (wStrb_q[0] && wData_q[HBM_CMD_SUB]) begin
               // High byte minus accumulator, flags as a subtract
               prodHigh_d = subRes;
               flags_d[HBM_FLAG_CARRY] = subSum[8];
               flags_d[HBM_FLAG_DIGIT] = subNib[4];
               flags_d[HBM_FLAG_ZERO] = (subRes == 8'h00);
               flags_d[HBM_FLAG_NEG] = subRes[7];
               flags_d[HBM_FLAG_OVER] = (prodHigh_q[7] != accum_q[7]) &&
                  (subRes[7] != prodHigh_q[7]);
            end
         end else begin
            // Unmapped address
            bResp_d = HBM_RESP_SLVERR;
         end
      end
      // Each ready only while its own channel holds nothing and no response is unanswered
      awReady_d = !awHeld_d && !bValid_d;
      wReady_d = !wHeld_d && !bValid_d;
   end

   // Register write side
   always_ff @(posedge clk) begin
      if (reset) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         awReady_q <= 1'b0;
         wReady_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= HBM_RESP_OKAY;
         prodLow_q <= HBM_RST_BYTE;
         prodHigh_q <= HBM_RST_BYTE;
         accum_q <= HBM_RST_BYTE;
         fileOp_q <= HBM_RST_BYTE;
         flags_q <= HBM_RST_FLAGS;
      end else begin
         awHeld_q <= awHeld_d;
         awAddr_q <= awAddr_d;
         wHeld_q <= wHeld_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         awReady_q <= awReady_d;
         wReady_q <= wReady_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         prodLow_q <= prodLow_d;
         prodHigh_q <= prodHigh_d;
         accum_q <= accum_d;
         fileOp_q <= fileOp_d;
         flags_q <= flags_d;
      end
   end

   // ***************************************************
   // Read channel
   // ***************************************************
   always_comb begin
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      // Answer taken
      if (rValid_q && rready) begin
         rValid_d = 1'b0;
      end
      if (arvalid && arReady_q) begin
         rValid_d = 1'b1;
         rResp_d = HBM_RESP_OKAY;
         rData_d = 32'h0000_0000;
         if (araddr == HBM_OFS_PROD_LOW) begin
            rData_d[7:0] = prodLow_q;
         end else if (araddr == HBM_OFS_PROD_HIGH) begin
            rData_d[7:0] = prodHigh_q;
         end else if (araddr == HBM_OFS_ACCUM) begin
            rData_d[7:0] = accum_q;
         end else if (araddr == HBM_OFS_FILE_OP) begin
            rData_d[7:0] = fileOp_q;
         end else if (araddr == HBM_OFS_FLAGS) begin
            rData_d[HBM_FLAG_W-1:0] = flags_q;
         end else if (araddr == HBM_OFS_COMMAND) begin
            // Command bits are pulses, read as zero
            rData_d = 32'h0000_0000;
         end else begin
            rResp_d = HBM_RESP_SLVERR;
         end
      end
      // One read in flight
      arReady_d = !rValid_d;
   end

   // Register read side
   always_ff @(posedge clk) begin
      if (reset) begin
         arReady_q <= 1'b0;
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= HBM_RESP_OKAY;
      end else begin
         arReady_q <= arReady_d;
         rValid_q <= rValid_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
      end
   end

   // ***************************************************
   // Outputs straight from flops
   // ***************************************************
   assign awready = awReady_q;
   assign wready = wReady_q;
   assign bvalid = bValid_q;
   assign bresp = bResp_q;
   assign arready = arReady_q;
   assign rvalid = rValid_q;
   assign rdata = rData_q;
   assign rresp = rResp_q;

endmodule

`default_nettype wire

//--- sim/hbm_top_props.sv
// Checker for the byte multiplier register slave
`timescale 1ns/1ps
`default_nettype none
module hbm_top_props
   import hbm_pkg::*;
#(
   parameter int ADDR_W = HBM_ADDR_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   // ***************************************************
   // Address of the read in flight
   // ***************************************************
   logic [ADDR_W-1:0] rdAddr_q;
   logic [ADDR_W-1:0] rdAddr_d;
   logic unmapped; // Read address outside the register map
   // Capture address at the read handshake
   always_comb begin
      rdAddr_d = rdAddr_q;
      if (arvalid && arready) begin
         rdAddr_d = araddr;
      end
   end
   always_ff @(posedge clk) begin
      rdAddr_q <= rdAddr_d;
   end
   assign unmapped = !(rdAddr_q inside {HBM_OFS_PROD_LOW, HBM_OFS_PROD_HIGH,
      HBM_OFS_ACCUM, HBM_OFS_FILE_OP, HBM_OFS_COMMAND, HBM_OFS_FLAGS});
   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   chk_write_latency: assert property (
      awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   chk_read_latency: assert property (
      arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_rdata_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
   chk_rdata_pad: assert property (
      rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_busy_ready: assert property (
      bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   chk_flags_pad: assert property (
      rvalid && rdAddr_q == HBM_OFS_FLAGS |-> rdata[7:5] == 3'h0)
      else $error("unused flag bits not zero");
   chk_unmapped_read: assert property (
      rvalid && unmapped
      |-> rresp == HBM_RESP_SLVERR && rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   cover property (awvalid && awready && wvalid && wready);
   cover property (rvalid && unmapped);
   cover property (rvalid && rdAddr_q == HBM_OFS_PROD_HIGH);
endmodule

bind hbm_top hbm_top_props #(.ADDR_W(ADDR_W)) u_hbm_top_props (
   .clk(clk), .reset(reset), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready)
);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the byte multiplier
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import hbm_pkg::*;
   // ***************************************************
   // Signals and tables
   // ***************************************************
   logic clk = 1'b0, reset = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_total = 0, checked = 0, cycles = 0;
   localparam logic [7:0] OPA [5] = '{8'hFF, 8'hFF, 8'h80, 8'h12, 8'h00};
   localparam logic [7:0] OPB [5] = '{8'hFF, 8'h01, 8'h02, 8'hB4, 8'h7F};
   localparam logic [11:0] REGS [5] = '{HBM_OFS_PROD_LOW, HBM_OFS_PROD_HIGH,
      HBM_OFS_ACCUM, HBM_OFS_FILE_OP, HBM_OFS_FLAGS};
   // Clock of 5 ns
   always #2.5 clk = ~clk;
   hbm_top u_hbm_top (.clk(clk), .reset(reset), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   // ***************************************************
   // Tasks
   // ***************************************************
   task automatic close_out();
      $display("compares %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bus write; response ready held up with the request
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      // Response taken at the edge where bvalid is seen
      r = bresp;
      bready <= 1'b0;
   endtask
   // Bus read; data taken at the handshake edge
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_total++;
         close_out();
      end
   end
   // ***************************************************
   // Test sequence
   // ***************************************************
   initial begin
      logic [31:0] v;
      logic [1:0] r;
      logic [7:0] f;
      logic signed [15:0] sa, sb, p;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      foreach (REGS[i]) begin
         rd(REGS[i], v, r);
         cmp("reset value", 32'h0000_0000, v);
         cmp("reset resp", 32'(HBM_RESP_OKAY), 32'(r));
      end
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         f = i[0] ? 8'h15 : 8'h0A;
         wr(HBM_OFS_ACCUM, OPA[i], 4'hF, r);
         wr(HBM_OFS_FILE_OP, OPB[i], 4'hF, r);
         wr(HBM_OFS_FLAGS, f, 4'hF, r);
         wr(HBM_OFS_COMMAND, 8'h01, 4'hF, r);
         cmp("mul resp", 32'(HBM_RESP_OKAY), 32'(r));
         p = 16'(OPA[i]) * 16'(OPB[i]);
         rd(HBM_OFS_PROD_LOW, v, r);
         cmp("product low", 32'(p[7:0]), v);
         rd(HBM_OFS_PROD_HIGH, v, r);
         cmp("product high", 32'(p[15:8]), v);
         rd(HBM_OFS_FLAGS, v, r);
         cmp("flags", 32'(f), v);
         rd(HBM_OFS_ACCUM, v, r);
         cmp("accumulator", 32'(OPA[i]), v);
         rd(HBM_OFS_FILE_OP, v, r);
         cmp("file operand", 32'(OPB[i]), v);
         // Software sign fix-up of the high byte
         if (OPB[i][7]) begin
            wr(HBM_OFS_COMMAND, 8'h02, 4'hF, r);
         end
         if (OPA[i][7]) begin
            wr(HBM_OFS_ACCUM, OPB[i], 4'hF, r);
            wr(HBM_OFS_COMMAND, 8'h02, 4'hF, r);
         end
         sa = $signed(OPA[i]);
         sb = $signed(OPB[i]);
         p = sa * sb;
         rd(HBM_OFS_PROD_HIGH, v, r);
         cmp("signed high", 32'(p[15:8]), v);
      end
      $display("test multiply table done");
      // Subtract with a borrow: zero minus one
      wr(HBM_OFS_PROD_HIGH, 8'h00, 4'hF, r);
      wr(HBM_OFS_ACCUM, 8'h01, 4'hF, r);
      wr(HBM_OFS_COMMAND, 8'h02, 4'hF, r);
      rd(HBM_OFS_PROD_HIGH, v, r);
      cmp("sub result", 32'h0000_00FF, v);
      rd(HBM_OFS_FLAGS, v, r);
      cmp("sub flags", 32'(1 << HBM_FLAG_NEG), v);
      rd(HBM_OFS_COMMAND, v, r);
      cmp("command reads zero", 32'h0000_0000, v);
      $display("test subtract done");
      wr(HBM_OFS_ACCUM, 8'h33, 4'hF, r);
      wr(HBM_OFS_ACCUM, 8'h5A, 4'h0, r);
      rd(HBM_OFS_ACCUM, v, r);
      cmp("masked write", 32'h0000_0033, v);
      wr(12'h020, 8'h77, 4'hF, r);
      cmp("unmapped wr resp", 32'(HBM_RESP_SLVERR), 32'(r));
      rd(12'h020, v, r);
      cmp("unmapped rd resp", 32'(HBM_RESP_SLVERR), 32'(r));
      cmp("unmapped rd data", 32'h0000_0000, v);
      $display("test refusals done");
      close_out();
   end
endmodule
`default_nettype wire
